// ---- bench/mlcr_mac_model.sv ----
// Behavioural MAC on the MII side of the timing core
`timescale 1ns/1ps
`default_nettype none
`include "mlcr_defines.svh"

module mlcr_mac_model (
  // Clock and scenario controls
  input wire logic clk_in,
  input wire logic send_in,
  input wire logic stall_in,
  // Transmit side
  input wire logic tx_strobe_in,
  output logic tx_en_out,
  output logic [`MLCR_NIB_W-1:0] txd_out,
  // Receive side
  input wire logic rx_dv_in,
  input wire logic [`MLCR_NIB_W-1:0] rxd_in,
  output logic rx_ready_out
);
  logic [`MLCR_NIB_W-1:0] seq_ff = 4'h1;
  logic [`MLCR_NIB_W-1:0] pat_ff = 4'h0;
  logic [`MLCR_NIB_W-1:0] rx_q[$];

  // No management clock is driven here, so its high, low and period limits hold trivially
  // Outside a frame the data lines change every cycle
  assign txd_out = tx_en_out ? seq_ff : pat_ff;
  initial begin
    tx_en_out = 1'b0;
    rx_ready_out = 1'b0;
  end
  // Once raised, enable only moves at a sampling edge so no nibble is cut short
  always @(posedge clk_in) begin
    pat_ff <= pat_ff + 4'h7;
    if (tx_strobe_in && tx_en_out) begin
      seq_ff <= seq_ff + 4'h5;
    end
    if (tx_strobe_in || !tx_en_out) begin
      tx_en_out <= send_in;
    end
    if (rx_dv_in && rx_ready_out) begin
      rx_q.push_back(rxd_in);
    end
    rx_ready_out <= !stall_in;
  end
endmodule
`default_nettype wire

// ---- bench/mlcr_phy_timing_asserts.sv ----
// Concurrent checks on the ports of the MII timing core
`timescale 1ns/1ps
`default_nettype none
`include "mlcr_defines.svh"

module mlcr_phy_timing_asserts #(
  parameter logic [`MLCR_TMR_W-1:0] POR_CYCLES = 23'h14,
  parameter logic [`MLCR_TMR_W-1:0] INIT_CYCLES = 23'h0a
) (
  // Clock, reset and straps
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic hardware_reset_input_n_in,
  input wire logic speed_100_in,
  input wire logic full_duplex_in,
  input wire logic phy_ready_out,
  // MII side
  input wire logic tx_nibble_strobe_out,
  input wire logic tx_en_in,
  input wire logic [`MLCR_NIB_W-1:0] txd_in,
  input wire logic rx_ready_in,
  input wire logic rx_dv_out,
  input wire logic [`MLCR_NIB_W-1:0] rxd_out,
  input wire logic rx_er_out,
  input wire logic crs_out,
  input wire logic col_out,
  // Line side
  input wire logic line_receive_pair_in,
  input wire logic line_rx_start_in,
  input wire logic line_rx_end_in,
  input wire logic line_transmit_pair_out,
  input wire logic line_tx_active_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  wire logic half_100 = speed_100_in && !full_duplex_in;
  wire logic half_10 = !speed_100_in && !full_duplex_in;
  wire logic tx_go = tx_nibble_strobe_out && tx_en_in;
  wire logic tx_stop = tx_nibble_strobe_out && !tx_en_in && line_tx_active_out;

  tx_first_bit_a: assert property (tx_go |=> line_tx_active_out &&
    line_transmit_pair_out == $past(txd_in[0])) else $error("transmit first bit wrong");
  tx_crs_on_a: assert property (half_100 && tx_go |-> ##[1:4] crs_out)
    else $error("carrier late after transmit start");
  tx_crs_off_a: assert property (half_100 && tx_stop |-> ##[1:4] !crs_out)
    else $error("carrier late to drop after transmit end");
  tx_crs_slow_a: assert property (half_10 && tx_go |-> ##[1:20] crs_out)
    else $error("slow carrier late after transmit start");
  rx_crs_on_a: assert property ($rose(line_rx_start_in) && speed_100_in |->
    ##[10:15] crs_out) else $error("receive carrier late");
  rx_col_on_a: assert property ($rose(line_rx_start_in) && half_100 && tx_en_in |->
    ##[9:14] col_out) else $error("collision late");
  rx_crs_off_a: assert property ($rose(line_rx_end_in) && speed_100_in && !tx_en_in |->
    ##[13:18] !crs_out) else $error("receive carrier late to drop");
  rx_col_off_a: assert property ($rose(line_rx_end_in) && speed_100_in |->
    ##[13:18] !col_out) else $error("collision late to drop");
  rx_fast_lat_a: assert property ($rose(line_rx_start_in) && speed_100_in && rx_ready_in &&
    !rx_dv_out |-> ##[1:18] rx_dv_out) else $error("first receive nibble late");
  rx_slow_lat_a: assert property ($rose(line_rx_start_in) && !speed_100_in && rx_ready_in &&
    !rx_dv_out |-> ##[1:71] rx_dv_out) else $error("first slow receive nibble late");
  hw_isolate_a: assert property (!hardware_reset_input_n_in [*4] |-> !phy_ready_out &&
    !crs_out && !col_out && !rx_dv_out && !line_tx_active_out && !tx_nibble_strobe_out)
    else $error("outputs active under hardware reset");
  hw_ready_a: assert property ($rose(hardware_reset_input_n_in) |-> ##[1:20] phy_ready_out)
    else $error("not ready after hardware reset");
endmodule

bind mlcr_phy_timing mlcr_phy_timing_asserts #(.POR_CYCLES(POR_CYCLES), .INIT_CYCLES(INIT_CYCLES))
  mlcr_phy_timing_asserts_inst (.clk_in, .reset_in, .ce_in, .hardware_reset_input_n_in,
  .speed_100_in, .full_duplex_in, .phy_ready_out, .tx_nibble_strobe_out, .tx_en_in, .txd_in,
  .rx_ready_in, .rx_dv_out, .rxd_out, .rx_er_out, .crs_out, .col_out, .line_receive_pair_in,
  .line_rx_start_in, .line_rx_end_in, .line_transmit_pair_out, .line_tx_active_out);
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the MII timing core
`timescale 1ns/1ps
`default_nettype none
`include "mlcr_defines.svh"

module tb_top;
  localparam logic [`MLCR_TMR_W-1:0] POR_C = 23'h14;
  localparam logic [`MLCR_TMR_W-1:0] INIT_C = 23'h0a;
  logic clk_in, reset_in, ce_in, hardware_reset_input_n_in, speed_100_in, full_duplex_in;
  logic phy_ready_out, tx_nibble_strobe_out, tx_en_in, rx_ready_in, rx_dv_out, rx_er_out;
  logic crs_out, col_out, line_receive_pair_in, line_rx_start_in, line_rx_end_in;
  logic line_transmit_pair_out, line_tx_active_out, send, stall, in_frame, lbit, idle_tog;
  logic [`MLCR_NIB_W-1:0] txd_in, rxd_out;
  int failures, comparisons;

  mlcr_phy_timing #(.POR_CYCLES(POR_C), .INIT_CYCLES(INIT_C)) mlcr_phy_timing_inst (
    .clk_in, .reset_in, .ce_in, .hardware_reset_input_n_in, .speed_100_in, .full_duplex_in,
    .phy_ready_out, .tx_nibble_strobe_out, .tx_en_in, .txd_in, .rx_ready_in, .rx_dv_out,
    .rxd_out, .rx_er_out, .crs_out, .col_out, .line_receive_pair_in, .line_rx_start_in,
    .line_rx_end_in, .line_transmit_pair_out, .line_tx_active_out);
  mlcr_mac_model mlcr_mac_model_inst (.clk_in, .send_in(send), .stall_in(stall),
    .tx_strobe_in(tx_nibble_strobe_out), .tx_en_out(tx_en_in), .txd_out(txd_in),
    .rx_dv_in(rx_dv_out), .rxd_in(rxd_out), .rx_ready_out(rx_ready_in));

  // Line shows a toggling level between frames
  assign line_receive_pair_in = in_frame ? lbit : idle_tog;
  always @(negedge clk_in) idle_tog <= ~idle_tog;
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  function automatic int bt();
    return speed_100_in ? 1 : 10;
  endfunction

  // Bits go out LSB first; the end marker follows the last data bit
  task automatic line_frame(input logic [15:0] d, input int nn);
    in_frame = 1'b1;
    for (int i = 0; i < nn * 4; i++) begin
      lbit = d[i];
      line_rx_start_in = (i == 0);
      cyc(bt());
    end
    line_rx_end_in = 1'b1;
    cyc(bt());
    line_rx_end_in = 1'b0;
    in_frame = 1'b0;
  endtask

  task automatic t_por;
    int n;
    n = 0;
    while (phy_ready_out !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk("por_cycles", n, POR_C);
    $display("power-on test done");
  endtask

  task automatic t_tx(input logic spd, input logic fd);
    logic [3:0] nib;
    int w;
    speed_100_in = spd;
    full_duplex_in = fd;
    send = 1'b1;
    repeat (3) begin
      w = 0;
      while (!(tx_nibble_strobe_out && tx_en_in) && w < 100) begin
        cyc(1);
        w++;
      end
      nib = txd_in;
      for (int i = 0; i < 4; i++) begin
        cyc(i == 0 ? 1 : bt());
        chk("tx_bit", line_transmit_pair_out, nib[i]);
      end
    end
    chk("tx_carrier", crs_out, !fd);
    send = 1'b0;
    cyc(20 * bt());
    chk("tx_line_idle", {line_tx_active_out, line_transmit_pair_out}, 0);
    chk("tx_carrier_off", crs_out, 0);
    $display("transmit test done");
  endtask

  task automatic t_rx(input logic spd, input logic stl, input logic [15:0] d, input int nn,
                      input int keep, input logic er);
    speed_100_in = spd;
    stall = stl;
    mlcr_mac_model_inst.rx_q.delete();
    line_frame(d, nn);
    cyc(20 * bt());
    chk("rx_carrier_off", crs_out, 0);
    chk("rx_overrun", rx_er_out, er);
    stall = 1'b0;
    cyc(10);
    chk("rx_count", mlcr_mac_model_inst.rx_q.size(), keep);
    for (int i = 0; i < keep; i++) begin
      // On overrun the waiting nibble is replaced by the newer one
      chk("rx_nibble", mlcr_mac_model_inst.rx_q[i], 4'(d >> (4 * ((er && i == keep - 1) ? i + 1 : i))));
    end
    $display("receive test done");
  endtask

  task automatic t_col;
    speed_100_in = 1'b1;
    full_duplex_in = 1'b0;
    send = 1'b1;
    cyc(10);
    line_frame(16'hf0f0, 4);
    chk("col_on", col_out, 1);
    cyc(20);
    chk("col_off", col_out, 0);
    chk("tx_carrier_held", crs_out, 1);
    send = 1'b0;
    cyc(20);
    chk("carrier_off", crs_out, 0);
    $display("collision test done");
  endtask

  task automatic t_hw;
    int n;
    stall = 1'b1;
    cyc(1);
    fork
      line_frame(16'h1234, 4);
    join_none
    cyc(16);
    hardware_reset_input_n_in = 1'b0;
    cyc(6);
    chk("hw_quiet", {phy_ready_out, crs_out, rx_dv_out, tx_nibble_strobe_out}, 0);
    cyc(50);
    hardware_reset_input_n_in = 1'b1;
    stall = 1'b0;
    n = 0;
    while (phy_ready_out !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk("hw_ready_span", n >= INIT_C && n <= INIT_C + 23'h5, 1);
    chk("hw_buffer_cleared", rx_dv_out, 0);
    $display("hardware reset test done");
  endtask

  initial begin
    cyc(20000);
    failures++;
    test_done;
  end

  initial begin
    ce_in = 1'b1;
    reset_in = 1'b1;
    hardware_reset_input_n_in = 1'b1;
    speed_100_in = 1'b1;
    full_duplex_in = 1'b0;
    {send, stall, in_frame, lbit, idle_tog, line_rx_start_in, line_rx_end_in} = 7'h00;
    failures = 0;
    comparisons = 0;
    cyc(8);
    reset_in = 1'b0;
    t_por;
    t_tx(1'b1, 1'b0);
    t_tx(1'b0, 1'b0);
    t_tx(1'b1, 1'b1);
    full_duplex_in = 1'b0;
    t_rx(1'b1, 1'b1, 16'h9e21, 4, 3, 1'b1);
    t_rx(1'b1, 1'b0, 16'h5a3c, 4, 4, 1'b0);
    t_rx(1'b0, 1'b0, 16'h00b7, 2, 2, 1'b0);
    t_col;
    t_hw;
    test_done;
  end
endmodule
`default_nettype wire

// ---- design/mlcr_defines.svh ----
// Timing constants, counts and field sizes for the MII latency, carrier and reset block
`ifndef MLCR_DEFINES_SVH
`define MLCR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Clock and bit time
// ----------------------------------------------------------------------------
`define MLCR_CLK_MHZ 100
`define MLCR_BIT_NS_10M 100
`define MLCR_BIT_CYC_10M ((`MLCR_BIT_NS_10M * `MLCR_CLK_MHZ) / 1000)
`define MLCR_RX_MID_10M 4'h4
`define MLCR_NS_TO_CYC_FLOOR(ns) (((ns) * `MLCR_CLK_MHZ) / 1000)
`define MLCR_MS_TO_CYC(ms) ((ms) * `MLCR_CLK_MHZ * 1000)

// ----------------------------------------------------------------------------
// Reset timing
// ----------------------------------------------------------------------------
`define MLCR_POR_MS 45
`define MLCR_POR_MIN_MS 40
`define MLCR_POR_MAX_MS 500
`define MLCR_INIT_MS 35
`define MLCR_INIT_MAX_MS 500
`define MLCR_ISO_NS 60
`define MLCR_ISO_CYC `MLCR_NS_TO_CYC_FLOOR(`MLCR_ISO_NS)
`define MLCR_POR_CYC `MLCR_MS_TO_CYC(`MLCR_POR_MS)
`define MLCR_INIT_CYC `MLCR_MS_TO_CYC(`MLCR_INIT_MS)
`define MLCR_TMR_W 23

// ----------------------------------------------------------------------------
// Carrier and collision delays, in bit ticks counted after the event
// ----------------------------------------------------------------------------
`define MLCR_CNT_W 5
`define MLCR_TXCRS_ON_100 5'h02
`define MLCR_TXCRS_OFF_100 5'h02
`define MLCR_TXCRS_ON_10 5'h00
`define MLCR_TXCRS_OFF_10 5'h01
`define MLCR_RXCRS_ON 5'h0a
`define MLCR_RXCOL_ON 5'h09
`define MLCR_RX_OFF 5'h0d

// ----------------------------------------------------------------------------
// Data path
// ----------------------------------------------------------------------------
`define MLCR_NIB_W 4
`define MLCR_BUF_DEPTH 2

`endif

// ---- design/mlcr_nib_buf.sv ----
// Two-entry nibble buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "mlcr_defines.svh"

module mlcr_nib_buf (
  // Clock and control
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic clear_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [`MLCR_NIB_W-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [`MLCR_NIB_W-1:0] out_data_out
);

  mlcr_pkg::mlcr_buf_t s_ff;
  mlcr_pkg::mlcr_buf_t nxt_s;
  logic push;
  logic pop;

  // --------------------------------------------------------------------------
  // Handshakes
  // --------------------------------------------------------------------------
  assign in_ready_out = (s_ff.cnt != 2'h2);
  assign out_valid_out = (s_ff.cnt != 2'h0);
  assign out_data_out = s_ff.mem[s_ff.rd];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.mem[s_ff.wr] = in_data_in;
      nxt_s.wr = ~s_ff.wr;
    end
    if (pop) begin
      nxt_s.rd = ~s_ff.rd;
    end
    if (push && !pop) begin
      nxt_s.cnt = s_ff.cnt + 2'h1;
    end else if (pop && !push) begin
      nxt_s.cnt = s_ff.cnt - 2'h1;
    end
    if (clear_in) begin
      nxt_s = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_ff <= '0;
    end else if (ce_in) begin
      s_ff <= nxt_s;
    end
  end

endmodule
`default_nettype wire

// ---- design/mlcr_phy_timing.sv ----
// MII-side timing core: line latencies, carrier and collision, reset sequencing
`timescale 1ns/1ps
`default_nettype none
`include "mlcr_defines.svh"

module mlcr_phy_timing #(
  parameter logic [`MLCR_TMR_W-1:0] POR_CYCLES = `MLCR_TMR_W'(`MLCR_POR_CYC),
  parameter logic [`MLCR_TMR_W-1:0] INIT_CYCLES = `MLCR_TMR_W'(`MLCR_INIT_CYC)
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Hardware reset pin and mode straps
  input wire logic hardware_reset_input_n_in,
  input wire logic speed_100_in,
  input wire logic full_duplex_in,
  output logic phy_ready_out,
  // MII transmit
  output logic tx_nibble_strobe_out,
  input wire logic tx_en_in,
  input wire logic [`MLCR_NIB_W-1:0] txd_in,
  // MII receive and status
  input wire logic rx_ready_in,
  output logic rx_dv_out,
  output logic [`MLCR_NIB_W-1:0] rxd_out,
  output logic rx_er_out,
  output logic crs_out,
  output logic col_out,
  // Line receive pair
  input wire logic line_receive_pair_in,
  input wire logic line_rx_start_in,
  input wire logic line_rx_end_in,
  // Line transmit pair
  output logic line_transmit_pair_out,
  output logic line_tx_active_out
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [`MLCR_CNT_W-1:0] mlcr_sel(
    input logic spd100,
    input logic [`MLCR_CNT_W-1:0] v100,
    input logic [`MLCR_CNT_W-1:0] v10
  );
    mlcr_sel = spd100 ? v100 : v10;
  endfunction

  function automatic logic [`MLCR_CNT_W-1:0] mlcr_sat_inc(
    input logic [`MLCR_CNT_W-1:0] v
  );
    mlcr_sat_inc = (v == '1) ? v : v + `MLCR_CNT_W'(1);
  endfunction

  localparam logic [3:0] BIT_LAST_10M = 4'(`MLCR_BIT_CYC_10M - 1);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  mlcr_pkg::mlcr_core_t s_ff;
  mlcr_pkg::mlcr_core_t nxt_s;
  mlcr_pkg::mlcr_core_t hold;
  logic hw_active;
  logic run;
  logic tick;
  logic rx_tick;
  logic tx_sample;
  logic sof_evt;
  logic eof_evt;
  logic rx_bit;
  logic nib_done;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [`MLCR_NIB_W-1:0] buf_out_data;
  logic [`MLCR_CNT_W-1:0] tx_target;

  // --------------------------------------------------------------------------
  // Decodes of registered state
  // --------------------------------------------------------------------------
  assign hw_active = ~s_ff.hr_s[1];
  assign run = (s_ff.st == mlcr_pkg::MLCR_ST_RUN) & ~hw_active;
  // One bit time is one cycle at 100M and ten cycles at 10M
  assign tick = speed_100_in | (s_ff.div == BIT_LAST_10M);
  assign rx_tick = speed_100_in | (s_ff.rx_div == `MLCR_RX_MID_10M);
  assign tx_sample = run & tick & (s_ff.bitn == 2'h0);
  assign sof_evt = s_ff.sof_s[1] & ~s_ff.sof_q;
  assign eof_evt = s_ff.eof_s[1] & ~s_ff.eof_q;
  assign rx_bit = s_ff.rxb_s[1];
  assign nib_done = run & s_ff.rx_frame & rx_tick & (s_ff.rx_nb == 2'h3);
  assign tx_target = s_ff.tx_en_q ?
    mlcr_sel(speed_100_in, `MLCR_TXCRS_ON_100, `MLCR_TXCRS_ON_10) :
    mlcr_sel(speed_100_in, `MLCR_TXCRS_OFF_100, `MLCR_TXCRS_OFF_10);

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign phy_ready_out = (s_ff.st == mlcr_pkg::MLCR_ST_RUN);
  assign tx_nibble_strobe_out = tx_sample;
  assign rx_dv_out = buf_out_valid;
  assign rxd_out = buf_out_data;
  assign rx_er_out = s_ff.rx_er;
  assign crs_out = s_ff.crs;
  assign col_out = s_ff.col;
  assign line_transmit_pair_out = s_ff.tx_line;
  assign line_tx_active_out = s_ff.tx_act;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    hold = s_ff;

    // Pin synchronisers and edge history
    nxt_s.hr_s = {s_ff.hr_s[0], hardware_reset_input_n_in};
    nxt_s.rxb_s = {s_ff.rxb_s[0], line_receive_pair_in};
    nxt_s.sof_s = {s_ff.sof_s[0], line_rx_start_in};
    nxt_s.eof_s = {s_ff.eof_s[0], line_rx_end_in};
    nxt_s.sof_q = s_ff.sof_s[1];
    nxt_s.eof_q = s_ff.eof_s[1];

    // Reset sequencer
    unique case (s_ff.st)
      mlcr_pkg::MLCR_ST_POR: begin
        if (s_ff.tmr == POR_CYCLES - `MLCR_TMR_W'(1)) begin
          nxt_s.st = mlcr_pkg::MLCR_ST_RUN;
          nxt_s.tmr = '0;
        end else begin
          nxt_s.tmr = s_ff.tmr + `MLCR_TMR_W'(1);
        end
      end
      mlcr_pkg::MLCR_ST_HWRST: begin
        nxt_s.tmr = '0;
        nxt_s.st = mlcr_pkg::MLCR_ST_INIT;
      end
      mlcr_pkg::MLCR_ST_INIT: begin
        if (s_ff.tmr == INIT_CYCLES - `MLCR_TMR_W'(1)) begin
          nxt_s.st = mlcr_pkg::MLCR_ST_RUN;
          nxt_s.tmr = '0;
        end else begin
          nxt_s.tmr = s_ff.tmr + `MLCR_TMR_W'(1);
        end
      end
      mlcr_pkg::MLCR_ST_RUN: begin
        nxt_s.tmr = '0;
      end
    endcase
    if (hw_active) begin
      nxt_s.st = mlcr_pkg::MLCR_ST_HWRST;
      nxt_s.tmr = '0;
    end

    // Bit and nibble timing
    nxt_s.div = tick ? 4'h0 : s_ff.div + 4'h1;
    if (tick) begin
      nxt_s.bitn = s_ff.bitn + 2'h1;
    end
    nxt_s.rx_div = (s_ff.rx_div == BIT_LAST_10M) ? 4'h0 : s_ff.rx_div + 4'h1;
    if (sof_evt) begin
      nxt_s.rx_div = 4'h0;
    end

    // Transmit serialiser, least significant bit first
    if (tx_sample) begin
      nxt_s.tx_en_q = tx_en_in;
      nxt_s.tx_act = tx_en_in;
      nxt_s.tx_line = tx_en_in & txd_in[0];
      nxt_s.tx_sh = tx_en_in ? (txd_in >> 1) : '0;
    end else if (tick) begin
      nxt_s.tx_line = s_ff.tx_act & s_ff.tx_sh[0];
      nxt_s.tx_sh = s_ff.tx_sh >> 1;
    end

    // Transmit carrier, timed from the enable change seen at sampling
    if (tx_sample && (tx_en_in != s_ff.tx_en_q)) begin
      nxt_s.tx_cnt = '0;
    end else if (tick) begin
      nxt_s.tx_cnt = mlcr_sat_inc(s_ff.tx_cnt);
    end
    if (s_ff.tx_cnt == tx_target) begin
      nxt_s.tx_crs = s_ff.tx_en_q;
    end

    // Receive frame tracking
    if (sof_evt) begin
      nxt_s.rx_frame = 1'b1;
      nxt_s.rx_cnt = '0;
      nxt_s.rx_nb = 2'h0;
      nxt_s.rx_er = 1'b0;
    end else if (eof_evt) begin
      nxt_s.rx_frame = 1'b0;
      nxt_s.rx_cnt = '0;
    end else if (rx_tick) begin
      nxt_s.rx_cnt = mlcr_sat_inc(s_ff.rx_cnt);
    end

    // Receive carrier and collision
    if (s_ff.rx_frame && s_ff.rx_cnt == `MLCR_RXCRS_ON) begin
      nxt_s.rx_crs = 1'b1;
    end else if (!s_ff.rx_frame && s_ff.rx_cnt == `MLCR_RX_OFF) begin
      nxt_s.rx_crs = 1'b0;
    end
    if (s_ff.rx_frame && s_ff.rx_cnt == `MLCR_RXCOL_ON && s_ff.tx_en_q && !full_duplex_in) begin
      nxt_s.col = 1'b1;
    end else if (!s_ff.rx_frame && s_ff.rx_cnt == `MLCR_RX_OFF) begin
      nxt_s.col = 1'b0;
    end
    if (full_duplex_in) begin
      nxt_s.col = 1'b0;
    end
    // Own transmission shows on carrier in half duplex only
    nxt_s.crs = (nxt_s.tx_crs & ~full_duplex_in) | nxt_s.rx_crs;

    // Receive deserialiser into the buffer, least significant bit first
    // At 100M the first bit stands on the synced line in the cycle the start is seen
    if (sof_evt && speed_100_in) begin
      nxt_s.rx_sh = {rx_bit, s_ff.rx_sh[`MLCR_NIB_W-1:1]};
      nxt_s.rx_nb = 2'h1;
    end else if (s_ff.rx_frame && rx_tick) begin
      nxt_s.rx_sh = {rx_bit, s_ff.rx_sh[`MLCR_NIB_W-1:1]};
      nxt_s.rx_nb = s_ff.rx_nb + 2'h1;
    end
    if (s_ff.rx_pend && buf_in_ready) begin
      nxt_s.rx_pend = 1'b0;
    end
    if (nib_done) begin
      nxt_s.rx_nib = {rx_bit, s_ff.rx_sh[`MLCR_NIB_W-1:1]};
      nxt_s.rx_pend = 1'b1;
      // A nibble still waiting when the next completes is lost
      if (s_ff.rx_pend && !buf_in_ready) begin
        nxt_s.rx_er = 1'b1;
      end
    end

    // Isolation: everything but sequencer, synchronisers and edge history held initial
    if (!run) begin
      hold = nxt_s;
      nxt_s = '0;
      nxt_s.st = hold.st;
      nxt_s.tmr = hold.tmr;
      nxt_s.hr_s = hold.hr_s;
      nxt_s.rxb_s = hold.rxb_s;
      nxt_s.sof_s = hold.sof_s;
      nxt_s.eof_s = hold.eof_s;
      nxt_s.sof_q = hold.sof_q;
      nxt_s.eof_q = hold.eof_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_ff <= '0;
      // Pin synchroniser starts at the released level so power-on does not look like a pin reset
      s_ff.hr_s <= 2'b11;
    end else if (ce_in) begin
      s_ff <= nxt_s;
    end
  end

  // --------------------------------------------------------------------------
  // Receive buffer
  // --------------------------------------------------------------------------
  mlcr_nib_buf u_rx_buf (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .clear_in(~run),
    .in_valid_in(s_ff.rx_pend),
    .in_ready_out(buf_in_ready),
    .in_data_in(s_ff.rx_nib),
    .out_valid_out(buf_out_valid),
    .out_ready_in(rx_ready_in),
    .out_data_out(buf_out_data)
  );

endmodule
`default_nettype wire

// ---- design/mlcr_pkg.sv ----
// Types shared by the MII latency, carrier and reset block
`include "mlcr_defines.svh"

package mlcr_pkg;

  // --------------------------------------------------------------------------
  // Reset sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MLCR_ST_POR = 2'b00,
    MLCR_ST_HWRST = 2'b01,
    MLCR_ST_INIT = 2'b10,
    MLCR_ST_RUN = 2'b11
  } mlcr_state_t;

  // --------------------------------------------------------------------------
  // Core state
  // --------------------------------------------------------------------------
  typedef struct packed {
    mlcr_state_t st;
    logic [`MLCR_TMR_W-1:0] tmr;
    logic [1:0] hr_s;
    logic [1:0] rxb_s;
    logic [1:0] sof_s;
    logic [1:0] eof_s;
    logic sof_q;
    logic eof_q;
    logic [3:0] div;
    logic [1:0] bitn;
    logic [`MLCR_NIB_W-1:0] tx_sh;
    logic tx_line;
    logic tx_act;
    logic tx_en_q;
    logic [`MLCR_CNT_W-1:0] tx_cnt;
    logic tx_crs;
    logic [3:0] rx_div;
    logic rx_frame;
    logic [`MLCR_CNT_W-1:0] rx_cnt;
    logic rx_crs;
    logic col;
    logic crs;
    logic [`MLCR_NIB_W-1:0] rx_sh;
    logic [1:0] rx_nb;
    logic rx_pend;
    logic [`MLCR_NIB_W-1:0] rx_nib;
    logic rx_er;
  } mlcr_core_t;

  // --------------------------------------------------------------------------
  // Two-entry buffer state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [`MLCR_BUF_DEPTH-1:0][`MLCR_NIB_W-1:0] mem;
    logic wr;
    logic rd;
    logic [1:0] cnt;
  } mlcr_buf_t;

endpackage
